// ---- csf_defines.vh ----
// Purpose: Shared constants for the charge state flag and load model block
// Assumes: Included by bare name from every design file
// Notes: Offsets are byte addresses on a 32-bit APB bus
`ifndef CSF_DEFINES_VH
`define CSF_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CSF_OFF_CTRL 8'h00
`define CSF_OFF_STATUS 8'h04
`define CSF_OFF_REMCAP 8'h08
`define CSF_OFF_DESIGN_CAP 8'h0c
`define CSF_OFF_INIT_THR 8'h10
`define CSF_OFF_FINAL_THR 8'h14
`define CSF_OFF_DSG_THR 8'h18
`define CSF_OFF_HOST_RATE 8'h1c
`define CSF_OFF_USER_CUR 8'h20
`define CSF_OFF_USER_POW 8'h24
`define CSF_OFF_RES_CHARGE 8'h28
`define CSF_OFF_RES_ENERGY 8'h2c
`define CSF_OFF_DESIGN_EN 8'h30
`define CSF_OFF_SEL_RATE 8'h34
`define CSF_OFF_AVG_CUR 8'h38
`define CSF_OFF_FULL_CAP 8'h3c
`define CSF_OFF_NOM_AVAIL 8'h40
`define CSF_OFF_FULL_AVAIL 8'h44

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CSF_CTRL_MODE 0
`define CSF_CTRL_SEL_LO 4
`define CSF_CTRL_SEL_HI 6
`define CSF_CTRL_POL 8
`define CSF_CTRL_RESCOMP 9
`define CSF_ST_INIT 0
`define CSF_ST_FINAL 1
`define CSF_ST_MODE 2
`define CSF_ST_DSG 3

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define CSF_MODE_CURRENT 1'b0
`define CSF_MODE_POWER 1'b1
`define CSF_SEL_RESET 3'h1
`define CSF_SEL_MAX 3'h6
`define CSF_POL_RESET 1'b1
`define CSF_DSG_THR_RESET 16'h0064
`define CSF_C_RATE_DIV 16'h0005

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CSF_CLK_HZ 10000000
`define CSF_TICK_S 1
`define CSF_TAU_S 14
`define CSF_MAS_PER_MAH 3600
`define CSF_UW_PER_10MW 10000
`define CSF_AVG_SHIFT 4

`endif

// ---- csf_host_model.sv ----
// Purpose: APB host model issuing register transfers to the gauge
// Assumes: Slave answers with pready within 50 cycles
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module csf_host_model (
  input wire logic sys_clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata
);
  initial begin
    paddr = 8'h00;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e, output logic ok);
    int n;
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    ok = 1'h0;
    n = 0;
    while (!ok && n < 50) begin
      @(posedge sys_clk);
      n++;
      ok = pready;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // csf_host_model
`default_nettype wire

// ---- csf_hyst_flag.v ----
// Purpose: Capacity warning flag with separate set and clear thresholds
// Assumes: Value and thresholds in mAh, updated on the enable pulse
// Notes: Set wins over clear when both hold in one update
`timescale 1ns/1ps
`default_nettype none
`include "csf_defines.vh"

module csf_hyst_flag #(
  parameter W = 16,
  parameter ZERO_DISABLES = 0
) (
  input wire clk,
  input wire rst_n,
  input wire updateEn,
  input wire [W-1:0] value,
  input wire [W-1:0] setThr,
  input wire [W-1:0] clrThr,
  output reg flag_q
);
  wire armed;
  wire setCond;
  wire clrCond;

  assign armed = (ZERO_DISABLES == 0) || (setThr != {W{1'b0}});
  assign setCond = armed && (value < setThr);
  assign clrCond = flag_q && (value > clrThr);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (updateEn) begin
      if (setCond) begin
        flag_q <= 1'b1;
      end else if (clrCond) begin
        flag_q <= 1'b0;
      end
    end
  end
endmodule // csf_hyst_flag
`default_nettype wire

// ---- csf_top.v ----
// Purpose: Charge tracking, low-charge flags, low-battery pin, load model select
// Assumes: senseCurrent is a signed mA result of the sense resistor front end,
//   positive while charging; cellVoltage is in mV; both synchronous to sys_clk
// Notes: Registers over APB with one wait state
`timescale 1ns/1ps
`default_nettype none
`include "csf_defines.vh"

module csf_top #(
  parameter TICK_CYCLES = `CSF_CLK_HZ * `CSF_TICK_S,
  parameter [15:0] DESIGN_CAP_RESET = 16'h03e8,
  parameter [15:0] DESIGN_EN_RESET = 16'h0172
) (
  input wire sys_clk,
  input wire resetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire signed [15:0] senseCurrent,
  input wire senseValid,
  input wire [15:0] cellVoltage,
  output reg lowBatteryPin
);
  // --------------------------------------------------------------------
  // Reset release and one-second tick
  // --------------------------------------------------------------------
  reg [1:0] rstSync_q;
  wire rstN;
  reg [31:0] tickCnt_q;
  reg tick_q;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      tickCnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (tickCnt_q == TICK_CYCLES - 1) begin
      tickCnt_q <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  reg loadMode_q;
  reg [2:0] loadSel_q;
  reg lowPol_q;
  reg resComp_q;
  reg [15:0] designCap_q, designEn_q, initSet_q, initClr_q, finalSet_q, finalClr_q;
  reg [15:0] dsgThr_q, hostRate_q, userCur_q, userPow_q, resCharge_q, resEnergy_q;
  reg [15:0] remCharge_q;
  reg [15:0] selRate_q;
  reg signed [15:0] avgCur_q;
  reg dsg_q;
  wire initFlag, finalFlag;
  wire [15:0] remReported, fullCharge;
  wire access, wrEn;
  reg [31:0] rdMux;
  reg rdHit;
  wire roHit;

  assign access = psel && penable && !pready;
  assign wrEn = psel && penable && pready && pwrite && !pslverr;
  assign roHit = (paddr == `CSF_OFF_STATUS) || (paddr >= `CSF_OFF_SEL_RATE);

  always @* begin
    rdMux = 32'h0;
    rdHit = 1'b1;
    case (paddr)
      `CSF_OFF_CTRL: rdMux = {22'h0, resComp_q, lowPol_q, 1'b0, loadSel_q, 3'h0, loadMode_q};
      `CSF_OFF_STATUS: rdMux = {25'h0, loadSel_q, dsg_q, loadMode_q, finalFlag, initFlag};
      `CSF_OFF_REMCAP: rdMux = {16'h0, remCharge_q};
      `CSF_OFF_DESIGN_CAP: rdMux = {16'h0, designCap_q};
      `CSF_OFF_INIT_THR: rdMux = {initClr_q, initSet_q};
      `CSF_OFF_FINAL_THR: rdMux = {finalClr_q, finalSet_q};
      `CSF_OFF_DSG_THR: rdMux = {16'h0, dsgThr_q};
      `CSF_OFF_HOST_RATE: rdMux = {16'h0, hostRate_q};
      `CSF_OFF_USER_CUR: rdMux = {16'h0, userCur_q};
      `CSF_OFF_USER_POW: rdMux = {16'h0, userPow_q};
      `CSF_OFF_RES_CHARGE: rdMux = {16'h0, resCharge_q};
      `CSF_OFF_RES_ENERGY: rdMux = {16'h0, resEnergy_q};
      `CSF_OFF_DESIGN_EN: rdMux = {16'h0, designEn_q};
      `CSF_OFF_SEL_RATE: rdMux = {16'h0, selRate_q};
      `CSF_OFF_AVG_CUR: rdMux = {{16{avgCur_q[15]}}, avgCur_q};
      `CSF_OFF_FULL_CAP: rdMux = {16'h0, fullCharge};
      `CSF_OFF_NOM_AVAIL: rdMux = {16'h0, remCharge_q};
      `CSF_OFF_FULL_AVAIL: rdMux = {16'h0, designCap_q};
      default: rdHit = 1'b0;
    endcase
  end

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= access;
      pslverr <= access && (!rdHit || (pwrite && roHit));
      prdata <= (access && !pwrite) ? rdMux : 32'h0;
    end
  end

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      loadMode_q <= `CSF_MODE_CURRENT;
      loadSel_q <= `CSF_SEL_RESET;
      lowPol_q <= `CSF_POL_RESET;
      resComp_q <= 1'b0;
      designCap_q <= DESIGN_CAP_RESET;
      designEn_q <= DESIGN_EN_RESET;
      initSet_q <= 16'h0;
      initClr_q <= 16'h0;
      finalSet_q <= 16'h0;
      finalClr_q <= 16'h0;
      dsgThr_q <= `CSF_DSG_THR_RESET;
      hostRate_q <= 16'h0;
      userCur_q <= 16'h0;
      userPow_q <= 16'h0;
      resCharge_q <= 16'h0;
      resEnergy_q <= 16'h0;
    end else if (wrEn) begin
      case (paddr)
        `CSF_OFF_CTRL: begin
          loadMode_q <= pwdata[`CSF_CTRL_MODE];
          if (pwdata[`CSF_CTRL_SEL_HI:`CSF_CTRL_SEL_LO] <= `CSF_SEL_MAX) begin
            loadSel_q <= pwdata[`CSF_CTRL_SEL_HI:`CSF_CTRL_SEL_LO];
          end
          lowPol_q <= pwdata[`CSF_CTRL_POL];
          resComp_q <= pwdata[`CSF_CTRL_RESCOMP];
        end
        `CSF_OFF_DESIGN_CAP: designCap_q <= pwdata[15:0];
        `CSF_OFF_INIT_THR: begin
          initSet_q <= pwdata[15:0];
          initClr_q <= pwdata[31:16];
        end
        `CSF_OFF_FINAL_THR: begin
          finalSet_q <= pwdata[15:0];
          finalClr_q <= pwdata[31:16];
        end
        `CSF_OFF_DSG_THR: dsgThr_q <= pwdata[15:0];
        `CSF_OFF_HOST_RATE: hostRate_q <= pwdata[15:0];
        `CSF_OFF_USER_CUR: userCur_q <= pwdata[15:0];
        `CSF_OFF_USER_POW: userPow_q <= pwdata[15:0];
        `CSF_OFF_RES_CHARGE: resCharge_q <= pwdata[15:0];
        `CSF_OFF_RES_ENERGY: resEnergy_q <= pwdata[15:0];
        `CSF_OFF_DESIGN_EN: designEn_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Charge integration
  // --------------------------------------------------------------------
  reg signed [31:0] residue_q;
  wire signed [31:0] resSum, stepMah, resNext, remSum;

  assign resSum = residue_q + {{16{senseCurrent[15]}}, senseCurrent};
  assign stepMah = resSum / `CSF_MAS_PER_MAH;
  assign resNext = resSum - stepMah * `CSF_MAS_PER_MAH;
  assign remSum = $signed({16'h0, remCharge_q}) + stepMah;

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      residue_q <= 32'sh0;
      remCharge_q <= 16'h0;
    end else if (wrEn && paddr == `CSF_OFF_REMCAP) begin
      remCharge_q <= pwdata[15:0];
      residue_q <= 32'sh0;
    end else if (tick_q) begin
      residue_q <= resNext;
      if (remSum < 0) begin
        remCharge_q <= 16'h0;
      end else if (remSum > $signed({16'h0, designCap_q})) begin
        remCharge_q <= designCap_q;
      end else begin
        remCharge_q <= remSum[15:0];
      end
    end
  end

  // Reserve is hidden from the reported figure and not load-scaled
  assign remReported = (remCharge_q > resCharge_q) ? remCharge_q - resCharge_q : 16'h0;
  assign fullCharge = (designCap_q > resCharge_q) ? designCap_q - resCharge_q : 16'h0;

  // --------------------------------------------------------------------
  // Warning flags and low-battery pin
  // --------------------------------------------------------------------
  csf_hyst_flag #(.W(16), .ZERO_DISABLES(0)) uInitFlag (
    .clk(sys_clk),
    .rst_n(rstN),
    .updateEn(1'b1),
    .value(remReported),
    .setThr(initSet_q),
    .clrThr(initClr_q),
    .flag_q(initFlag)
  );

  csf_hyst_flag #(.W(16), .ZERO_DISABLES(1)) uFinalFlag (
    .clk(sys_clk),
    .rst_n(rstN),
    .updateEn(1'b1),
    .value(remReported),
    .setThr(finalSet_q),
    .clrThr(finalClr_q),
    .flag_q(finalFlag)
  );

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      lowBatteryPin <= ~`CSF_POL_RESET;
    end else begin
      lowBatteryPin <= lowPol_q ? initFlag : ~initFlag;
    end
  end

  // --------------------------------------------------------------------
  // Discharge detection and averages
  // --------------------------------------------------------------------
  reg signed [15:0] filtCur_q, prevCur_q, prevPow_q;
  reg signed [31:0] sumCur_q, sumPow_q;
  reg [15:0] dsgCnt_q;
  wire signed [16:0] dsgMag, avgDiff, filtDiff;
  wire signed [31:0] powNow, powAvg, powFilt, presCur, presPow, filtStep;
  wire signed [15:0] avgStep;

  assign dsgMag = -$signed({senseCurrent[15], senseCurrent});
  assign avgDiff = $signed({senseCurrent[15], senseCurrent}) - $signed({avgCur_q[15], avgCur_q});
  assign filtDiff = $signed({avgCur_q[15], avgCur_q}) - $signed({filtCur_q[15], filtCur_q});
  assign avgStep = $signed(avgDiff[16:1]) >>> (`CSF_AVG_SHIFT - 1);
  assign filtStep = filtDiff / `CSF_TAU_S;
  assign powNow = (senseCurrent * $signed({16'h0, cellVoltage})) / `CSF_UW_PER_10MW;
  assign powAvg = (avgCur_q * $signed({16'h0, cellVoltage})) / `CSF_UW_PER_10MW;
  assign powFilt = (filtCur_q * $signed({16'h0, cellVoltage})) / `CSF_UW_PER_10MW;
  assign presCur = (dsgCnt_q == 16'h0) ? {{16{prevCur_q[15]}}, prevCur_q}
                                       : sumCur_q / $signed({16'h0, dsgCnt_q});
  assign presPow = (dsgCnt_q == 16'h0) ? {{16{prevPow_q[15]}}, prevPow_q}
                                       : sumPow_q / $signed({16'h0, dsgCnt_q});

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      dsg_q <= 1'b0;
      avgCur_q <= 16'sh0;
    end else if (senseValid) begin
      dsg_q <= dsgMag > $signed({1'b0, dsgThr_q});
      avgCur_q <= avgCur_q + avgStep;
    end
  end

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      filtCur_q <= 16'sh0;
      prevCur_q <= 16'sh0;
      prevPow_q <= 16'sh0;
      sumCur_q <= 32'sh0;
      sumPow_q <= 32'sh0;
      dsgCnt_q <= 16'h0;
    end else if (tick_q) begin
      filtCur_q <= filtCur_q + filtStep[15:0];
      if (dsg_q) begin
        sumCur_q <= sumCur_q - {{16{senseCurrent[15]}}, senseCurrent};
        sumPow_q <= sumPow_q - powNow;
        dsgCnt_q <= dsgCnt_q + 16'h1;
      end else if (dsgCnt_q != 16'h0) begin
        prevCur_q <= presCur[15:0];
        prevPow_q <= presPow[15:0];
        sumCur_q <= 32'sh0;
        sumPow_q <= 32'sh0;
        dsgCnt_q <= 16'h0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Load model rate source
  // --------------------------------------------------------------------
  reg [15:0] rateMux;
  wire [15:0] avgMagCur, filtMagCur, avgMagPow, filtMagPow;

  assign avgMagCur = avgCur_q[15] ? -avgCur_q : 16'h0;
  assign filtMagCur = filtCur_q[15] ? -filtCur_q : 16'h0;
  assign avgMagPow = powAvg[31] ? -powAvg[15:0] : 16'h0;
  assign filtMagPow = powFilt[31] ? -powFilt[15:0] : 16'h0;

  always @* begin
    rateMux = selRate_q;
    if (loadMode_q == `CSF_MODE_CURRENT) begin
      case (loadSel_q)
        3'h0: rateMux = prevCur_q;
        3'h1: rateMux = presCur[15:0];
        3'h2: rateMux = avgMagCur;
        3'h3: rateMux = filtMagCur;
        3'h4: rateMux = designCap_q / `CSF_C_RATE_DIV;
        3'h5: rateMux = hostRate_q;
        3'h6: rateMux = userCur_q;
        default: rateMux = selRate_q;
      endcase
    end else begin
      case (loadSel_q)
        3'h0: rateMux = prevPow_q;
        3'h1: rateMux = presPow[15:0];
        3'h2: rateMux = avgMagPow;
        3'h3: rateMux = filtMagPow;
        3'h4: rateMux = designEn_q / `CSF_C_RATE_DIV;
        3'h5: rateMux = hostRate_q;
        3'h6: rateMux = userPow_q;
        default: rateMux = selRate_q;
      endcase
    end
  end

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      selRate_q <= 16'h0;
    end else begin
      selRate_q <= rateMux;
    end
  end
endmodule // csf_top
`default_nettype wire

// ---- csf_top_properties.sv ----
// Purpose: Port-level checks of the charge state flag block
// Assumes: Bound to csf_top; control fields tracked from APB writes
// Notes: Reserved select values leave the tracked select unchanged
`timescale 1ns/1ps
`default_nettype none
`include "csf_defines.vh"
module csf_top_properties (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lowBatteryPin
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic mode_q;
  logic pol_q;
  logic [2:0] sel_q;
  wire ctrlWr = pready && pwrite && !pslverr && paddr == `CSF_OFF_CTRL;
  wire ctrlRd = pready && !pwrite && paddr == `CSF_OFF_CTRL;
  wire stRd = pready && !pwrite && paddr == `CSF_OFF_STATUS;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= 1'h0;
      pol_q <= 1'h1;
      sel_q <= 3'h1;
    end else if (ctrlWr) begin
      mode_q <= pwdata[0];
      pol_q <= pwdata[8];
      if (pwdata[6:4] <= 3'h6) begin
        sel_q <= pwdata[6:4];
      end
    end
  end
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_wait_state: assert property (psel && $rose(penable) |=> pready)
    else $error("pready not in second access cycle");
  a_ready_in_access: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside answer");
  a_unmapped_err: assert property (pready && paddr > `CSF_OFF_FULL_AVAIL |-> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");
  a_readonly_err: assert property (pready && pwrite && paddr == `CSF_OFF_STATUS |-> pslverr)
    else $error("status write not refused");
  a_mode_mirror: assert property (stRd |-> prdata[`CSF_ST_MODE] == mode_q)
    else $error("status mode bit differs from load mode");
  a_sel_reserved: assert property (ctrlRd |-> prdata[6:4] == sel_q && prdata[0] == mode_q)
    else $error("control select or mode differs");
  a_pin_follows: assert property (stRd |-> lowBatteryPin == (pol_q ? prdata[0] : !prdata[0]))
    else $error("low battery pin differs from initial flag");
endmodule // csf_top_properties
bind csf_top csf_top_properties i_csf_top_properties (.sys_clk(sys_clk), .resetn(resetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .lowBatteryPin(lowBatteryPin));
`default_nettype wire

// ---- csf_top_test.sv ----
// Purpose: Self-checking bench of the charge state flag block
// Assumes: Tick shortened to 20 cycles; 3600 mA for one tick moves one mAh
// Notes: Register table rows first, then model, threshold and flag tests
`timescale 1ns/1ps
`default_nettype none
module csf_top_test;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} csf_row_t;
  localparam int RATED_MAH = 500;
  localparam int PARALLEL = 2;
  logic sys_clk = 1'h0;
  logic resetn;
  logic signed [15:0] senseCurrent;
  logic senseValid;
  logic [15:0] cellVoltage;
  logic polBit = 1'h1;
  wire logic [7:0] paddr;
  wire logic psel, penable, pwrite, pready, pslverr, lowBatteryPin;
  wire logic [31:0] pwdata, prdata;
  int err_total = 0;
  int n_compared = 0;
  always #50 sys_clk = ~sys_clk;
  csf_top #(.TICK_CYCLES(20)) i_csf_top (.sys_clk(sys_clk), .resetn(resetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .senseCurrent(senseCurrent), .senseValid(senseValid),
    .cellVoltage(cellVoltage), .lowBatteryPin(lowBatteryPin));
  csf_host_model i_csf_host_model (.sys_clk(sys_clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata));
  // Write, address, write data, expected read data, expected error
  csf_row_t rows [0:29] = '{
    {1'h0, 8'h00, 32'h0, 32'h110, 1'h0}, {1'h0, 8'h18, 32'h0, 32'h64, 1'h0},
    {1'h0, 8'h0c, 32'h0, 32'h3e8, 1'h0}, {1'h0, 8'h30, 32'h0, 32'h172, 1'h0},
    {1'h1, 8'h0c, 32'(RATED_MAH * PARALLEL), 32'h0, 1'h0},
    {1'h0, 8'h48, 32'h0, 32'h0, 1'h1}, {1'h1, 8'h04, 32'hf, 32'h0, 1'h1},
    {1'h1, 8'h1c, 32'h1234, 32'h0, 1'h0}, {1'h1, 8'h20, 32'h321, 32'h0, 1'h0},
    {1'h1, 8'h24, 32'h456, 32'h0, 1'h0}, {1'h1, 8'h00, 32'h140, 32'h0, 1'h0},
    {1'h0, 8'h34, 32'h0, 32'hc8, 1'h0}, {1'h1, 8'h00, 32'h150, 32'h0, 1'h0},
    {1'h0, 8'h34, 32'h0, 32'h1234, 1'h0}, {1'h1, 8'h00, 32'h160, 32'h0, 1'h0},
    {1'h0, 8'h34, 32'h0, 32'h321, 1'h0}, {1'h1, 8'h00, 32'h171, 32'h0, 1'h0},
    {1'h0, 8'h00, 32'h0, 32'h161, 1'h0}, {1'h0, 8'h34, 32'h0, 32'h456, 1'h0},
    {1'h1, 8'h00, 32'h141, 32'h0, 1'h0}, {1'h0, 8'h34, 32'h0, 32'h4a, 1'h0},
    {1'h1, 8'h00, 32'h151, 32'h0, 1'h0}, {1'h0, 8'h34, 32'h0, 32'h1234, 1'h0},
    {1'h1, 8'h28, 32'h32, 32'h0, 1'h0}, {1'h0, 8'h3c, 32'h0, 32'h3b6, 1'h0},
    {1'h0, 8'h44, 32'h0, 32'h3e8, 1'h0}, {1'h1, 8'h28, 32'h0, 32'h0, 1'h0},
    {1'h1, 8'h08, 32'hd5, 32'h0, 1'h0}, {1'h1, 8'h10, 32'h00d200c8, 32'h0, 1'h0},
    {1'h0, 8'h40, 32'h0, 32'hd5, 1'h0}};
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    logic ok;
    i_csf_host_model.xfer(w, a, d, r, e, ok);
    check("pready", 32'h1, {31'h0, ok});
    if (ok !== 1'h1) finish_test();
  endtask
  task automatic stat(input logic ei, input logic ef);
    logic [31:0] r;
    logic e;
    bus(1'h0, 8'h04, 32'h0, r, e);
    check("initial flag", {31'h0, ei}, {31'h0, r[0]});
    check("final flag", {31'h0, ef}, {31'h0, r[1]});
    check("low pin", {31'h0, polBit ? ei : !ei}, {31'h0, lowBatteryPin});
  endtask
  // Runs current until the remaining charge reaches the target, then stops it
  task automatic drive(input logic signed [15:0] cur, input logic [15:0] target);
    logic [31:0] r;
    logic e;
    int n;
    senseCurrent <= cur;
    n = 0;
    do begin
      bus(1'h0, 8'h08, 32'h0, r, e);
      n++;
    end while (n < 200 && (cur < 0 ? r[15:0] > target : r[15:0] < target));
    senseCurrent <= 16'sh0;
    check("remaining charge", {16'h0, target}, r);
    check("charge in time", 32'h1, {31'h0, n < 200});
    if (n >= 200) finish_test();
  endtask
  initial begin : main
    logic [31:0] r;
    logic e;
    resetn = 1'h0;
    senseCurrent = 16'sh0;
    senseValid = 1'h0;
    cellVoltage = 16'h0e74;
    repeat (16) @(posedge sys_clk);
    check("pin in reset", 32'h0, {31'h0, lowBatteryPin});
    resetn <= 1'h1;
    senseValid <= 1'h1;
    repeat (3) @(posedge sys_clk);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d, r, e);
      if (!rows[i].wr) check($sformatf("row %0d data", i), rows[i].e, r);
      check($sformatf("row %0d error", i), {31'h0, rows[i].err}, {31'h0, e});
    end
    $display("test table done");
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        bus(1'h1, 8'h00, {23'h0, 1'h1, 1'h0, s[2:0], 3'h0, m[0]}, r, e);
        bus(1'h0, 8'h34, 32'h0, r, e);
        check("idle model rate", 32'h0, r);
      end
    end
    bus(1'h1, 8'h00, 32'h110, r, e);
    $display("test models done");
    for (int k = 100; k < 102; k++) begin
      senseCurrent <= -k[15:0];
      repeat (3) @(posedge sys_clk);
      bus(1'h0, 8'h04, 32'h0, r, e);
      check("discharging", 32'(k - 100), {31'h0, r[3]});
    end
    senseCurrent <= 16'sh0;
    $display("test discharge threshold done");
    bus(1'h1, 8'h14, 32'h0, r, e);
    stat(1'h0, 1'h0);
    drive(-16'sd3600, 16'd198);
    stat(1'h1, 1'h0);
    bus(1'h1, 8'h14, 32'h00c300be, r, e);
    drive(-16'sd3600, 16'd188);
    stat(1'h1, 1'h1);
    drive(16'sd3600, 16'd193);
    stat(1'h1, 1'h1);
    drive(16'sd3600, 16'd197);
    stat(1'h1, 1'h0);
    polBit = 1'h0;
    bus(1'h1, 8'h00, 32'h010, r, e);
    repeat (2) @(posedge sys_clk);
    stat(1'h1, 1'h0);
    drive(16'sd3600, 16'd212);
    stat(1'h0, 1'h0);
    $display("test flags done");
    resetn <= 1'h0;
    repeat (2) @(posedge sys_clk);
    check("pin in mid reset", 32'h0, {31'h0, lowBatteryPin});
    resetn <= 1'h1;
    polBit = 1'h1;
    repeat (3) @(posedge sys_clk);
    bus(1'h0, 8'h00, 32'h0, r, e);
    check("control after reset", 32'h110, r);
    stat(1'h0, 1'h0);
    $display("test mid reset done");
    finish_test();
  end
endmodule // csf_top_test
`default_nettype wire
